// File: dmb_defs.vh
// constants for the data memory bank addressing block
// assumes inclusion by bare name from the design files
`ifndef DMB_DEFS_VH
`define DMB_DEFS_VH
`define DMB_ADDR_W        12
`define DMB_BANK_W        4
`define DMB_OFFS_W        8
`define DMB_NUM_BANKS     16
`define DMB_BANK_BYTES    256
`define DMB_BANK_SEL_RESET 8'h00
`define DMB_ACC_SPLIT     8'h80
`define DMB_ACC_LOW_BANK  4'h0
`define DMB_ACC_HIGH_BANK 4'hF
`define DMB_SPECIAL_BASE  12'hF80
`define DMB_SPECIAL_TOP   12'hFFF
`define DMB_BANK_SEL_ADDR 12'hFE0
`define DMB_RAM_BASE      12'h000
`define DMB_Q_READ        2'h1
`define DMB_Q_WRITE       2'h3
`endif

// File: dmb_addr_gen.v
// effective address former for one operand
// assumes operand and bank value are stable during the instruction cycle
`default_nettype none
module dmb_addr_gen (
    // selection inputs
    input  wire [3:0]  bankNum,
    input  wire [7:0]  offset,
    input  wire        accessSel,
    input  wire        fullAddrMode,
    input  wire [11:0] fullAddr,
    // result
    output reg  [11:0] effAddr
);
`include "dmb_defs.vh"
    always @* begin
        if (fullAddrMode) begin
            effAddr = fullAddr;
        end else if (accessSel) begin
            effAddr = {bankNum, offset};
        end else if (offset < `DMB_ACC_SPLIT) begin
            effAddr = {`DMB_ACC_LOW_BANK, offset};
        end else begin
            effAddr = {`DMB_ACC_HIGH_BANK, offset};
        end
    end
endmodule // dmb_addr_gen
`default_nettype wire

// File: dmb_data_mem.v
// data memory with banked and access-bank addressing
// assumes the core drives one instruction per four ref_clk quarter cycles
//
// Contract
// - data memory address is twelve bits wide.
// - sixteen banks of 256 bytes, all implemented only with the default RAM_TOP and SPECIAL_MASK.
// - banked address uses bank register low nibble and operand low byte.
// - bank register keeps low four bits; upper bits read zero.
// - a load-literal instruction writes the bank register directly.
// - writes to unimplemented space are dropped; reads return zero.
// - status flags update as if unimplemented accesses succeeded.
// - full-address move uses twelve-bit addresses, ignoring bank register.
// - other instructions give eight-bit offset via bank or access map.
// - select bit one uses bank register; zero uses access map.
// - access-map access completes in one cycle without bank update.
// - mapping shown holds only while extended set is disabled; here it is kept with the extended set enabled too.
// - general RAM starts at 000h, not cleared by any reset.
// - special registers occupy F80h to FFFh as static storage.
// - unimplemented locations read all zeros.
// - operand read in quarter two, destination written in quarter four.
`default_nettype none
module dmb_data_mem #(
    parameter RAM_TOP      = 12'hF7F,
    parameter SPECIAL_MASK = 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // instruction side
    input  wire        instrValid,
    input  wire        accessSel,
    input  wire [7:0]  srcOffset,
    input  wire [7:0]  dstOffset,
    input  wire        full_address_move_instr,
    input  wire [11:0] srcFullAddr,
    input  wire [11:0] dstFullAddr,
    input  wire        load_bank_literal_instr,
    input  wire [7:0]  bankLiteral,
    input  wire        writeEn,
    input  wire [7:0]  writeData,
    input  wire        extended_set_enable,
    // results
    output reg  [7:0]  readData,
    output reg         readValid,
    output reg         writeDone,
    output wire        statusUpdate,
    output reg  [1:0]  qPhase,
    output wire [7:0]  bank_select_reg,
    output wire [11:0] srcAddr,
    output wire [11:0] dstAddr
);
`include "dmb_defs.vh"
    // ********************
    // local constants
    // ********************
    // the reset value is a full byte; only its low nibble is stored
    localparam [7:0]  BANK_SEL_RESET = `DMB_BANK_SEL_RESET;
    localparam [3:0]  BANK_RESET_LO  = BANK_SEL_RESET[3:0];
    localparam [11:0] BANK_SEL_ADDR  = `DMB_BANK_SEL_ADDR;
    localparam [11:0] SPECIAL_BASE   = `DMB_SPECIAL_BASE;

    // ********************
    // quarter cycle states
    // ********************
    localparam [3:0] Q1 = 4'b0001;
    localparam [3:0] Q2 = 4'b0010;
    localparam [3:0] Q3 = 4'b0100;
    localparam [3:0] Q4 = 4'b1000;
    reg [3:0] qState_r;
    reg [3:0] qState_nxt;
    reg [3:0] bank_number_bits_r;
    reg [7:0] mem_r [0:4095];
    reg [7:0] srcByte;
    wire      srcImpl;
    wire      dstImpl;
    wire      accSelEff;
    wire      execRead;
    wire      execWrite;
    wire      bankLoad;
    wire      bankWrite;
    wire      memWrite;

    // quarter counter free-runs; instructions are framed by instrValid
    always @* begin
        case (qState_r)
            Q1: qState_nxt = Q2;
            Q2: qState_nxt = Q3;
            Q3: qState_nxt = Q4;
            Q4: qState_nxt = Q1;
            default: qState_nxt = Q1;
        endcase
    end
    always @(posedge ref_clk) begin
        if (srst) begin
            qState_r <= Q1;
        end else begin
            qState_r <= qState_nxt;
        end
    end
    always @* begin
        case (qState_r)
            Q2: qPhase = `DMB_Q_READ;
            Q3: qPhase = 2'h2;
            Q4: qPhase = `DMB_Q_WRITE;
            default: qPhase = 2'h0;
        endcase
    end

    // ********************
    // execute strobes
    // ********************
    // operand fetch closes with the second quarter, results land at the fourth
    assign execRead  = instrValid && (qState_r == Q2);
    assign execWrite = instrValid && (qState_r == Q4);
    // a literal bank load never touches the array, even if writeEn is high
    assign bankLoad  = execWrite && load_bank_literal_instr;
    assign bankWrite = execWrite && !load_bank_literal_instr && writeEn
                       && (dstAddr == BANK_SEL_ADDR);
    assign memWrite  = execWrite && !load_bank_literal_instr && writeEn
                       && dstImpl;

    // ********************
    // addressing
    // ********************
    // limitation: the remapped access window of the extended instruction set
    // is not built; extended_set_enable is accepted but the plain map is kept,
    // so software relying on the remap must leave the extended set disabled
    assign accSelEff = accessSel;
    dmb_addr_gen uSrc (
        .bankNum      (bank_number_bits_r),
        .offset       (srcOffset),
        .accessSel    (accSelEff),
        .fullAddrMode (full_address_move_instr),
        .fullAddr     (srcFullAddr),
        .effAddr      (srcAddr)
    );
    dmb_addr_gen uDst (
        .bankNum      (bank_number_bits_r),
        .offset       (dstOffset),
        .accessSel    (accSelEff),
        .fullAddrMode (full_address_move_instr),
        .fullAddr     (dstFullAddr),
        .effAddr      (dstAddr)
    );

    // implemented = general RAM up to RAM_TOP or a populated special slot;
    // the gap between them reads zero and swallows writes
    function implAt;
        input [11:0] a;
        begin
            if (a >= SPECIAL_BASE) begin
                implAt = SPECIAL_MASK[a[6:0]];
            end else begin
                implAt = (a <= RAM_TOP);
            end
        end
    endfunction
    assign srcImpl = implAt(srcAddr);
    assign dstImpl = implAt(dstAddr);

    // ********************
    // bank select register
    // ********************
    assign bank_select_reg = {4'h0, bank_number_bits_r};
    // a literal load wins over a plain write within one instruction
    always @(posedge ref_clk) begin
        if (srst) begin
            bank_number_bits_r <= BANK_RESET_LO;
        end else if (bankLoad) begin
            bank_number_bits_r <= bankLiteral[3:0];
        end else if (bankWrite) begin
            // upper written bits are dropped, not stored
            bank_number_bits_r <= writeData[3:0];
        end
    end

    // ********************
    // storage and data path
    // ********************
    // the bank register shadows its own array slot on reads
    always @* begin
        if (srcAddr == BANK_SEL_ADDR) begin
            srcByte = bank_select_reg;
        end else if (srcImpl) begin
            srcByte = mem_r[srcAddr];
        end else begin
            srcByte = 8'h00;
        end
    end

    // no reset on the array: contents survive every reset
    always @(posedge ref_clk) begin
        if (memWrite) begin
            mem_r[dstAddr] <= writeData;
        end
    end
    // readData stands until the next read, so a slow core may pick it up late
    always @(posedge ref_clk) begin
        if (srst) begin
            readData  <= 8'h00;
            readValid <= 1'b0;
            writeDone <= 1'b0;
        end else begin
            readValid <= execRead;
            // a dropped write still completes, as the core sees it
            writeDone <= execWrite && writeEn;
            if (execRead) begin
                readData <= srcByte;
            end
        end
    end

    // ********************
    // status flags
    // ********************
    // flags update whether or not the target exists, so code behaves the same
    // on parts with less RAM; moves and bank loads leave the flags alone
    assign statusUpdate = execWrite && !full_address_move_instr
                          && !load_bank_literal_instr;
endmodule // dmb_data_mem
`default_nettype wire

// File: dmb_data_mem_assertions.sv
// port checks for the data memory block
// assumes one clock, srst synchronous active high
`default_nettype none
module dmb_data_mem_chk (
    input wire logic        ref_clk, srst, instrValid, accessSel,
    input wire logic        full_address_move_instr, writeEn, readValid,
    input wire logic        writeDone, statusUpdate,
    input wire logic        load_bank_literal_instr,
    input wire logic [1:0]  qPhase,
    input wire logic [7:0]  srcOffset, bank_select_reg,
    input wire logic [11:0] srcFullAddr, dstFullAddr, srcAddr, dstAddr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence quarterWalk;
        qPhase == 2'h1 ##1 qPhase == 2'h2 ##1 qPhase == 2'h3;
    endsequence
    AST_QUARTERS: assert property (qPhase == 2'h0 |=> quarterWalk)
        else $error("quarter order broken");
    AST_READ: assert property (qPhase == 2'h1 && instrValid |=> readValid)
        else $error("read not after second quarter");
    AST_READ_ONLY: assert property (readValid |-> $past(qPhase) == 2'h1)
        else $error("read pulse out of place");
    AST_WRITE: assert property (qPhase == 2'h3 && instrValid && writeEn |=> writeDone)
        else $error("write not after fourth quarter");
    AST_STATUS: assert property (statusUpdate |-> qPhase == 2'h3)
        else $error("status update outside fourth quarter");
    AST_BANKED: assert property (accessSel && !full_address_move_instr
        |-> srcAddr == {bank_select_reg[3:0], srcOffset}) else $error("banked address wrong");
    AST_ACCESS: assert property (!accessSel && !full_address_move_instr
        |-> srcAddr == {{4{srcOffset[7]}}, srcOffset}) else $error("access map wrong");
    AST_FULL: assert property (full_address_move_instr
        |-> srcAddr == srcFullAddr && dstAddr == dstFullAddr) else $error("full move address");
    AST_BANK_HIGH: assert property (bank_select_reg[7:4] == 4'h0)
        else $error("bank upper bits set");
    AST_STATUS_ANY: assert property (qPhase == 2'h3 && instrValid && !full_address_move_instr
        && !load_bank_literal_instr |-> statusUpdate) else $error("status update missing");
endmodule // dmb_data_mem_chk
bind dmb_data_mem dmb_data_mem_chk chk_u (
    .ref_clk                 (ref_clk),
    .srst                    (srst),
    .instrValid              (instrValid),
    .accessSel               (accessSel),
    .full_address_move_instr (full_address_move_instr),
    .writeEn                 (writeEn),
    .readValid               (readValid),
    .writeDone               (writeDone),
    .statusUpdate            (statusUpdate),
    .load_bank_literal_instr (load_bank_literal_instr),
    .qPhase                  (qPhase),
    .srcOffset               (srcOffset),
    .bank_select_reg         (bank_select_reg),
    .srcFullAddr             (srcFullAddr),
    .dstFullAddr             (dstFullAddr),
    .srcAddr                 (srcAddr),
    .dstAddr                 (dstAddr)
);
`default_nettype wire

// File: dmb_core_model.sv
// core execute side: presents one instruction per four quarters
// assumes issue is raised by the bench ahead of a fourth quarter
`default_nettype none
module dmb_core_model (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic [1:0] qPhase,
    input wire logic       issue,
    output var logic       instrValid
);
    // aligned to Q1 so operand read and write land in their quarters
    always @(posedge ref_clk) begin
        if (srst) instrValid <= 1'h0;
        else if (qPhase == 2'h3) instrValid <= issue;
    end
endmodule // dmb_core_model
`default_nettype wire

// File: data_memory_bank_addressing_test.sv
// self-checking bench for the data memory block
// assumes dmb_core_model frames instructions; extended set held off
`default_nettype none
module data_memory_bank_addressing_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, srst = 1'h1, issue = 1'h0, instrValid, readValid, writeDone;
    logic accessSel, full_address_move_instr, load_bank_literal_instr, writeEn;
    logic extended_set_enable, statusUpdate;
    logic [1:0] qPhase;
    logic [7:0] srcOffset, dstOffset, bankLiteral, writeData, readData, bank_select_reg;
    logic [11:0] srcFullAddr, dstFullAddr, srcAddr, dstAddr;
    int n_mismatch = 0, checks = 0;
    // *****************************
    // harness
    // *****************************
    // small RAM top leaves 600h-F7Fh unimplemented
    dmb_data_mem #(
        .RAM_TOP (12'h5FF)
    ) dut_u (
        .ref_clk                 (ref_clk),
        .srst                    (srst),
        .instrValid              (instrValid),
        .accessSel               (accessSel),
        .srcOffset               (srcOffset),
        .dstOffset               (dstOffset),
        .full_address_move_instr (full_address_move_instr),
        .srcFullAddr             (srcFullAddr),
        .dstFullAddr             (dstFullAddr),
        .load_bank_literal_instr (load_bank_literal_instr),
        .bankLiteral             (bankLiteral),
        .writeEn                 (writeEn),
        .writeData               (writeData),
        .extended_set_enable     (extended_set_enable),
        .readData                (readData),
        .readValid               (readValid),
        .writeDone               (writeDone),
        .statusUpdate            (statusUpdate),
        .qPhase                  (qPhase),
        .bank_select_reg         (bank_select_reg),
        .srcAddr                 (srcAddr),
        .dstAddr                 (dstAddr)
    );
    dmb_core_model core_u (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .qPhase     (qPhase),
        .issue      (issue),
        .instrValid (instrValid)
    );
    initial forever #50 ref_clk = ~ref_clk;
    initial {accessSel, full_address_move_instr, load_bank_literal_instr, writeEn,
        extended_set_enable, srcOffset, dstOffset, bankLiteral, writeData,
        srcFullAddr, dstFullAddr} = 61'h0;
    task automatic chk(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // k = access select, full move, bank load, write enable
    task automatic go(input logic [3:0] k, input logic [7:0] o, d, input logic [11:0] f);
        @(posedge ref_clk);
        {accessSel, full_address_move_instr, load_bank_literal_instr, writeEn} <= k;
        {srcOffset, dstOffset, bankLiteral, writeData} <= {o, o, o, d};
        {srcFullAddr, dstFullAddr} <= {f, f};
        issue <= 1'h1;
        @(negedge ref_clk iff instrValid);
        @(posedge ref_clk);
        issue <= 1'h0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic t_bank();
        go(4'h2, 8'hA5, 8'h00, 12'h000);
        chk(bank_select_reg, 8'h05);
        go(4'h9, 8'h12, 8'h3C, 12'h000);
        go(4'h4, 8'h00, 8'h00, 12'h512);
        chk(readData, 8'h3C);
        $display("t_bank done");
    endtask
    task automatic t_access();
        go(4'h1, 8'h10, 8'h77, 12'h000);
        go(4'h1, 8'h85, 8'h5A, 12'h000);
        go(4'h4, 8'h00, 8'h00, 12'h010);
        chk(readData, 8'h77);
        go(4'h4, 8'h00, 8'h00, 12'hF85);
        chk(readData, 8'h5A);
        $display("t_access done");
    endtask
    task automatic t_unimpl();
        go(4'h5, 8'h00, 8'hAA, 12'h700);
        go(4'h4, 8'h00, 8'h00, 12'h700);
        chk(readData, 8'h00);
        go(4'h2, 8'h07, 8'h00, 12'h000);
        go(4'h9, 8'h34, 8'hC3, 12'h000);
        go(4'h8, 8'h34, 8'h00, 12'h000);
        chk(readData, 8'h00);
        $display("t_unimpl done");
    endtask
    task automatic t_reset();
        // reset is sampled on a fourth-quarter edge so the quarter walk stays whole
        @(negedge ref_clk iff qPhase == 2'h2);
        @(posedge ref_clk);
        srst <= 1'h1;
        @(posedge ref_clk);
        srst <= 1'h0;
        go(4'h4, 8'h00, 8'h00, 12'h010);
        chk(readData, 8'h77);
        chk(bank_select_reg, 8'h00);
        $display("t_reset done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'h0;
        t_bank();
        t_access();
        t_unimpl();
        t_reset();
        report_and_stop();
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // data_memory_bank_addressing_test
`default_nettype wire
